// File: cpq_pkg.sv
// Package: constants, field layout and default cache table for the cache parameter query
package cpq_pkg;

   // ==========================================================
   // Query leaf selection
   localparam logic [31:0] CPQ_LEAF_CACHE_PARAMS = 32'h0000_0004;
   localparam logic [31:0] CPQ_LEAF_LAST_ALWAYS = 32'h0000_0003;
   localparam logic [31:0] CPQ_LEAF_EXT_BASE = 32'h8000_0000;

   // ==========================================================
   // Miscellaneous enable register
   localparam int CPQ_MISC_LEGACY_LIMIT_BIT = 22;
   localparam logic [31:0] CPQ_MISC_RESET = 32'h0000_0000;

   // ==========================================================
   // First result word layout
   localparam int CPQ_TYPE_LSB = 0;
   localparam int CPQ_TYPE_W = 5;
   localparam int CPQ_LEVEL_LSB = 5;
   localparam int CPQ_LEVEL_W = 3;
   localparam int CPQ_SELF_INIT_BIT = 8;
   localparam int CPQ_FULL_ASSOC_BIT = 9;
   localparam int CPQ_SHARE_LSB = 14;
   localparam int CPQ_SHARE_W = 12;
   localparam int CPQ_CORES_LSB = 26;
   localparam int CPQ_CORES_W = 6;

   // ==========================================================
   // Second and third result word layout
   localparam int CPQ_LINE_LSB = 0;
   localparam int CPQ_LINE_W = 12;
   localparam int CPQ_PARTS_LSB = 12;
   localparam int CPQ_PARTS_W = 10;
   localparam int CPQ_WAYS_LSB = 22;
   localparam int CPQ_WAYS_W = 10;
   localparam int CPQ_SETS_W = 32;
   localparam int CPQ_SIZE_W = 66;

   // ==========================================================
   // Reset values and table sizing
   localparam logic [31:0] CPQ_WORD_RESET = 32'h0000_0000;
   localparam logic [CPQ_SIZE_W-1:0] CPQ_SIZE_RESET = '0;
   localparam int CPQ_NUM_CACHES = 3;
   localparam int CPQ_TABLE_DEPTH = 4;

   typedef enum logic [CPQ_TYPE_W-1:0] {
      CPQ_CT_NULL = 5'h00,
      CPQ_CT_DATA = 5'h01,
      CPQ_CT_INSTR = 5'h02,
      CPQ_CT_UNIFIED = 5'h03
   } cpq_cache_type_t;

   typedef enum logic [1:0] {
      CPQ_ST_IDLE = 2'b00,
      CPQ_ST_LOOKUP = 2'b01,
      CPQ_ST_ANSWER = 2'b11
   } cpq_state_t;

   // All counts held minus one
   typedef struct packed {
      logic [CPQ_TYPE_W-1:0] ctype;
      logic [CPQ_LEVEL_W-1:0] level;
      logic self_init;
      logic full_assoc;
      logic [CPQ_SHARE_W-1:0] share_m1;
      logic [CPQ_CORES_W-1:0] cores_m1;
      logic [CPQ_LINE_W-1:0] line_m1;
      logic [CPQ_PARTS_W-1:0] parts_m1;
      logic [CPQ_WAYS_W-1:0] ways_m1;
      logic [CPQ_SETS_W-1:0] sets_m1;
   } cpq_desc_t;

   localparam cpq_desc_t CPQ_DESC_NULL = '0;

   // Default hierarchy: L1 data, L1 instruction, L2 unified, then nothing
   localparam cpq_desc_t CPQ_DEF_TABLE [CPQ_TABLE_DEPTH] = '{
      '{5'h01, 3'h1, 1'b1, 1'b0, 12'h001, 6'h00, 12'h03F, 10'h000, 10'h007, 32'h0000_003F},
      '{5'h02, 3'h1, 1'b1, 1'b0, 12'h001, 6'h00, 12'h03F, 10'h000, 10'h007, 32'h0000_003F},
      '{5'h03, 3'h2, 1'b1, 1'b0, 12'h001, 6'h00, 12'h03F, 10'h000, 10'h007, 32'h0000_03FF},
      '{5'h00, 3'h0, 1'b0, 1'b0, 12'h000, 6'h00, 12'h000, 10'h000, 10'h000, 32'h0000_0000}
   };

endpackage

// File: cpq_desc_if.sv
// Interface: cache index request and descriptor answer between query logic and table
`timescale 1ns/1ps
interface cpq_desc_if;
   import cpq_pkg::*;
   logic [31:0] index;
   cpq_desc_t desc;
   modport lookup (output index, input desc);
   modport table_side (input index, output desc);
endinterface

// File: cpq_desc_table.sv
// Descriptor table holding one cache descriptor per index
`timescale 1ns/1ps
module cpq_desc_table #(
   parameter int NUM_CACHES = cpq_pkg::CPQ_NUM_CACHES
) (
   cpq_desc_if.table_side port
);
   import cpq_pkg::*;

   cpq_desc_t table_mem [CPQ_TABLE_DEPTH];

   // ==========================================================
   // Table fill
   // Indices past the configured cache count read as the null entry
   for (genvar g = 0; g < CPQ_TABLE_DEPTH; g++) begin : g_entry
      assign table_mem[g] = (g < NUM_CACHES) ? CPQ_DEF_TABLE[g] : CPQ_DESC_NULL;
   end

   // ==========================================================
   // Lookup
   always_comb begin
      port.desc = CPQ_DESC_NULL;
      if (port.index < 32'(CPQ_TABLE_DEPTH)) begin
         port.desc = table_mem[port.index[$clog2(CPQ_TABLE_DEPTH)-1:0]];
      end
   end

endmodule // cpq_desc_table

// File: cpq_query.sv
// Top: cache parameter query responder with miscellaneous enable register
// ==========================================================
`timescale 1ns/1ps
module cpq_query #(
   parameter int NUM_CACHES = cpq_pkg::CPQ_NUM_CACHES
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic query_valid_in,
   input wire logic [31:0] query_leaf_in,
   input wire logic [31:0] query_index_in,
   input wire logic misc_wr_in,
   input wire logic [31:0] misc_wdata_in,
   output logic query_ready_out,
   output logic answer_valid_out,
   output logic [31:0] first_result_word_out,
   output logic [31:0] second_result_word_out,
   output logic [31:0] third_result_word_out,
   output logic [31:0] fourth_result_word_out,
   output logic [cpq_pkg::CPQ_SIZE_W-1:0] cache_size_out,
   output logic leaf_hidden_out,
   output logic leaf_unhandled_out,
   output logic no_more_caches_out,
   output logic [31:0] misc_enable_register_out
);
   import cpq_pkg::*;

   cpq_state_t state_ff;
   cpq_state_t nxt_state;
   logic ready_ff;
   logic answer_valid_ff;
   logic [31:0] leaf_ff;
   logic [31:0] index_ff;
   logic [31:0] misc_enable_register_ff;
   logic [31:0] first_word_ff;
   logic [31:0] second_word_ff;
   logic [31:0] third_word_ff;
   logic [31:0] fourth_word_ff;
   logic [CPQ_SIZE_W-1:0] cache_size_ff;
   logic leaf_hidden_ff;
   logic leaf_unhandled_ff;
   logic no_more_ff;
   logic take_query;
   logic serve_leaf;
   logic gated_now;
   cpq_desc_t desc;
   logic [CPQ_SIZE_W-1:0] size_calc;

   cpq_desc_if desc_bus ();

   // ==========================================================
   // Helpers
   // Leaves in this window vanish under the legacy leaf limit
   function automatic logic leaf_in_gated_range(input logic [31:0] leaf);
      return (leaf > CPQ_LEAF_LAST_ALWAYS) && (leaf < CPQ_LEAF_EXT_BASE);
   endfunction

   function automatic logic [31:0] pack_first(input cpq_desc_t d);
      logic [31:0] w;
      w = CPQ_WORD_RESET;
      w[CPQ_TYPE_LSB +: CPQ_TYPE_W] = d.ctype;
      w[CPQ_LEVEL_LSB +: CPQ_LEVEL_W] = d.level;
      w[CPQ_SELF_INIT_BIT] = d.self_init;
      w[CPQ_FULL_ASSOC_BIT] = d.full_assoc;
      w[CPQ_SHARE_LSB +: CPQ_SHARE_W] = d.share_m1;
      w[CPQ_CORES_LSB +: CPQ_CORES_W] = d.cores_m1;
      return w;
   endfunction

   function automatic logic [31:0] pack_second(input cpq_desc_t d);
      logic [31:0] w;
      w = CPQ_WORD_RESET;
      w[CPQ_LINE_LSB +: CPQ_LINE_W] = d.line_m1;
      w[CPQ_PARTS_LSB +: CPQ_PARTS_W] = d.parts_m1;
      w[CPQ_WAYS_LSB +: CPQ_WAYS_W] = d.ways_m1;
      return w;
   endfunction

   // ==========================================================
   // Descriptor table
   assign desc_bus.index = index_ff;
   assign desc = desc_bus.desc;

   cpq_desc_table #(
      .NUM_CACHES(NUM_CACHES)
   ) u_table (
      .port(desc_bus.table_side)
   );

   // ==========================================================
   // Query acceptance and leaf decode
   assign take_query = query_valid_in && ready_ff;
   assign gated_now = misc_enable_register_ff[CPQ_MISC_LEGACY_LIMIT_BIT]
                      && leaf_in_gated_range(leaf_ff);
   assign serve_leaf = (leaf_ff == CPQ_LEAF_CACHE_PARAMS) && !gated_now;

   // Full width product: four fields sum to 64 bits in width, the product reaches 65 bits
   assign size_calc = (CPQ_SIZE_W'(desc.ways_m1) + CPQ_SIZE_W'(1))
                    * (CPQ_SIZE_W'(desc.parts_m1) + CPQ_SIZE_W'(1))
                    * (CPQ_SIZE_W'(desc.line_m1) + CPQ_SIZE_W'(1))
                    * (CPQ_SIZE_W'(desc.sets_m1) + CPQ_SIZE_W'(1));

   // ==========================================================
   // Sequencer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         CPQ_ST_IDLE: begin
            if (take_query) begin
               nxt_state = CPQ_ST_LOOKUP;
            end
         end
         CPQ_ST_LOOKUP: begin
            nxt_state = CPQ_ST_ANSWER;
         end
         CPQ_ST_ANSWER: begin
            nxt_state = CPQ_ST_IDLE;
         end
         default: begin
            nxt_state = CPQ_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         state_ff <= CPQ_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Single query in flight; a new one waits for the answer to clear
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         ready_ff <= 1'b0;
      end else begin
         ready_ff <= (nxt_state == CPQ_ST_IDLE);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         leaf_ff <= CPQ_WORD_RESET;
         index_ff <= CPQ_WORD_RESET;
      end else if (take_query) begin
         leaf_ff <= query_leaf_in;
         index_ff <= query_index_in;
      end
   end

   // ==========================================================
   // Miscellaneous enable register
   // Cleared at reset so the cache leaf is visible by default
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         misc_enable_register_ff <= CPQ_MISC_RESET;
      end else if (misc_wr_in) begin
         misc_enable_register_ff <= misc_wdata_in;
      end
   end

   // ==========================================================
   // Answer words
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         first_word_ff <= CPQ_WORD_RESET;
         second_word_ff <= CPQ_WORD_RESET;
         third_word_ff <= CPQ_WORD_RESET;
         fourth_word_ff <= CPQ_WORD_RESET;
         cache_size_ff <= CPQ_SIZE_RESET;
      end else if (state_ff == CPQ_ST_LOOKUP) begin
         // Hidden or foreign leaves answer all zero
         fourth_word_ff <= CPQ_WORD_RESET;
         if (serve_leaf) begin
            first_word_ff <= pack_first(desc);
            second_word_ff <= pack_second(desc);
            third_word_ff <= desc.sets_m1;
            cache_size_ff <= (desc.ctype == CPQ_CT_NULL) ? CPQ_SIZE_RESET : size_calc;
         end else begin
            first_word_ff <= CPQ_WORD_RESET;
            second_word_ff <= CPQ_WORD_RESET;
            third_word_ff <= CPQ_WORD_RESET;
            cache_size_ff <= CPQ_SIZE_RESET;
         end
      end
   end

   // ==========================================================
   // Answer status
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         answer_valid_ff <= 1'b0;
      end else begin
         answer_valid_ff <= (state_ff == CPQ_ST_LOOKUP);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         leaf_hidden_ff <= 1'b0;
         leaf_unhandled_ff <= 1'b0;
         no_more_ff <= 1'b0;
      end else if (state_ff == CPQ_ST_LOOKUP) begin
         leaf_hidden_ff <= gated_now;
         leaf_unhandled_ff <= !gated_now && (leaf_ff != CPQ_LEAF_CACHE_PARAMS);
         // Tells the caller to stop walking the index
         no_more_ff <= serve_leaf && (desc.ctype == CPQ_CT_NULL);
      end
   end

   // ==========================================================
   // Outputs
   assign query_ready_out = ready_ff;
   assign answer_valid_out = answer_valid_ff;
   assign first_result_word_out = first_word_ff;
   assign second_result_word_out = second_word_ff;
   assign third_result_word_out = third_word_ff;
   assign fourth_result_word_out = fourth_word_ff;
   assign cache_size_out = cache_size_ff;
   assign leaf_hidden_out = leaf_hidden_ff;
   assign leaf_unhandled_out = leaf_unhandled_ff;
   assign no_more_caches_out = no_more_ff;
   assign misc_enable_register_out = misc_enable_register_ff;

endmodule // cpq_query

// File: cpq_query_chk.sv
// Checker: port-level assertions for the cache parameter query
`timescale 1ns/1ps
module cpq_query_chk (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic query_valid_in,
   input wire logic [31:0] query_leaf_in,
   input wire logic misc_wr_in,
   input wire logic [31:0] misc_wdata_in,
   input wire logic query_ready_out,
   input wire logic answer_valid_out,
   input wire logic [31:0] first_result_word_out,
   input wire logic [31:0] second_result_word_out,
   input wire logic [31:0] third_result_word_out,
   input wire logic [31:0] fourth_result_word_out,
   input wire logic [cpq_pkg::CPQ_SIZE_W-1:0] cache_size_out,
   input wire logic leaf_hidden_out,
   input wire logic leaf_unhandled_out,
   input wire logic no_more_caches_out,
   input wire logic [31:0] misc_enable_register_out
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   logic take;
   logic [31:0] w0;
   logic [31:0] w1;
   assign take = query_valid_in && query_ready_out;
   assign w0 = first_result_word_out;
   assign w1 = second_result_word_out;
   property p_latency; take |=> !answer_valid_out ##1 answer_valid_out; endproperty
   property p_ready; take |=> !query_ready_out[*2] ##1 query_ready_out; endproperty
   property p_pulse; answer_valid_out |=> !answer_valid_out; endproperty
   property p_rsvd;
      answer_valid_out |-> w0[13:10] == 4'h0 && fourth_result_word_out == 32'h0 && w0[4:0] <= 5'h03;
   endproperty
   property p_nomore;
      answer_valid_out && !leaf_hidden_out && !leaf_unhandled_out
         |-> no_more_caches_out == (w0[4:0] == 5'h00);
   endproperty
   property p_hidden;
      (take && query_leaf_in > 32'h3 && query_leaf_in < 32'h8000_0000)
         ##1 misc_enable_register_out[22] |=> leaf_hidden_out && w0 == 32'h0;
   endproperty
   property p_shown;
      (take && query_leaf_in == 32'h4) ##1 !misc_enable_register_out[22]
         |=> !leaf_hidden_out && !leaf_unhandled_out;
   endproperty
   property p_misc; misc_wr_in |=> misc_enable_register_out == $past(misc_wdata_in); endproperty
   property p_size;
      answer_valid_out && w0[4:0] != 5'h00 |-> cache_size_out == (66'(w1[31:22]) + 66'h1)
         * (66'(w1[21:12]) + 66'h1) * (66'(w1[11:0]) + 66'h1) * (66'(third_result_word_out) + 66'h1);
   endproperty
   property p_hold;
      !$rose(answer_valid_out) |-> $stable(third_result_word_out) && $stable(cache_size_out);
   endproperty
   a_latency: assert property (p_latency) else $error("answer latency wrong");
   a_ready: assert property (p_ready) else $error("ready timing wrong");
   a_pulse: assert property (p_pulse) else $error("answer not a pulse");
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   a_nomore: assert property (p_nomore) else $error("end flag wrong");
   a_hidden: assert property (p_hidden) else $error("leaf not hidden");
   a_shown: assert property (p_shown) else $error("leaf wrongly hidden");
   a_misc: assert property (p_misc) else $error("enable word wrong");
   a_size: assert property (p_size) else $error("size product wrong");
   a_hold: assert property (p_hold) else $error("words moved");
   c_hidden: cover property (answer_valid_out && leaf_hidden_out);
   c_nomore: cover property (answer_valid_out && no_more_caches_out);
   c_size: cover property (answer_valid_out && cache_size_out != 66'h0);
endmodule // cpq_query_chk

bind cpq_query cpq_query_chk i_chk (.*);

// File: cpq_caller.sv
// Partner: software side issuing processor identify queries
`timescale 1ns/1ps
module cpq_caller (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic go_in,
   input wire logic [31:0] leaf_in,
   input wire logic [31:0] index_in,
   input wire logic query_ready_in,
   output logic query_valid_out,
   output logic [31:0] query_leaf_out,
   output logic [31:0] query_index_out
);
   logic vld = 1'h0;
   logic taken = 1'h0;
   logic [31:0] leaf = 32'h0;
   logic [31:0] idx = 32'h0;
   assign query_valid_out = vld;
   assign query_leaf_out = leaf;
   assign query_index_out = idx;
   // ==========================================================
   // Request held until a ready edge takes it
   always @(posedge sys_clk_in) taken <= vld && query_ready_in;
   always @(negedge sys_clk_in) begin
      if (!reset_n_in) begin
         vld <= 1'h0;
      end else if (go_in && !vld) begin
         vld <= 1'h1;
         leaf <= leaf_in;
         idx <= index_in;
      end else if (taken) begin
         // Released lines show the inverse, not stale data
         vld <= 1'h0;
         leaf <= ~leaf;
         idx <= ~idx;
      end
   end
endmodule // cpq_caller

// File: cache_parameter_query_bench.sv
// Testbench: cache parameter query responder against the caller model
`timescale 1ns/1ps
module cache_parameter_query_bench;
   import cpq_pkg::*;
   typedef struct packed {
      logic [31:0] leaf;
      logic [31:0] idx;
      logic hide;
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] w2;
      logic [CPQ_SIZE_W-1:0] size;
      logic [2:0] fl;
   } cpq_row_t;
   logic sys_clk, reset_n, go, misc_wr, vld, ready, ans, hid, unh, nomore;
   logic [31:0] leaf, idx, q_leaf, q_idx, misc_wdata, misc_q, w0, w1, w2, w3;
   logic [CPQ_SIZE_W-1:0] size;
   int miscompares = 0;
   int checked = 0;
   // ==========================================================
   // Rows: leaf, index, hide bit, words, size, {hidden, unhandled, end}
   cpq_row_t rows [11] = '{
      '{32'h4, 32'h0, 1'h0, 32'h4121, 32'h01C0_003F, 32'h3F, 66'h8000, 3'h0},
      '{32'h4, 32'h1, 1'h0, 32'h4122, 32'h01C0_003F, 32'h3F, 66'h8000, 3'h0},
      '{32'h4, 32'h2, 1'h0, 32'h4143, 32'h01C0_003F, 32'h3FF, 66'h80000, 3'h0},
      '{32'h4, 32'h3, 1'h0, 32'h0, 32'h0, 32'h0, 66'h0, 3'h1},
      '{32'h4, 32'h9, 1'h0, 32'h0, 32'h0, 32'h0, 66'h0, 3'h1},
      '{32'h3, 32'h0, 1'h0, 32'h0, 32'h0, 32'h0, 66'h0, 3'h2},
      '{32'h4, 32'h0, 1'h1, 32'h0, 32'h0, 32'h0, 66'h0, 3'h4},
      '{32'h7FFF_FFFF, 32'h0, 1'h1, 32'h0, 32'h0, 32'h0, 66'h0, 3'h4},
      '{32'h8000_0000, 32'h0, 1'h1, 32'h0, 32'h0, 32'h0, 66'h0, 3'h2},
      '{32'h3, 32'h0, 1'h1, 32'h0, 32'h0, 32'h0, 66'h0, 3'h2},
      '{32'h4, 32'h2, 1'h0, 32'h4143, 32'h01C0_003F, 32'h3FF, 66'h80000, 3'h0}
   };
   cpq_caller i_caller (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .go_in(go),
      .leaf_in(leaf), .index_in(idx), .query_ready_in(ready), .query_valid_out(vld),
      .query_leaf_out(q_leaf), .query_index_out(q_idx));
   cpq_query i_dut (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .query_valid_in(vld),
      .query_leaf_in(q_leaf), .query_index_in(q_idx), .misc_wr_in(misc_wr),
      .misc_wdata_in(misc_wdata), .query_ready_out(ready), .answer_valid_out(ans),
      .first_result_word_out(w0), .second_result_word_out(w1), .third_result_word_out(w2),
      .fourth_result_word_out(w3), .cache_size_out(size), .leaf_hidden_out(hid),
      .leaf_unhandled_out(unh), .no_more_caches_out(nomore),
      .misc_enable_register_out(misc_q));
   // ==========================================================
   // Tasks
   task automatic stop_test;
      if (miscompares == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [65:0] seen, input logic [65:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic misc_write(input logic [31:0] d);
      @(negedge sys_clk);
      misc_wr <= 1'h1;
      misc_wdata <= d;
      @(negedge sys_clk);
      misc_wr <= 1'h0;
      misc_wdata <= ~d;
   endtask
   task automatic issue(input logic [31:0] l, input logic [31:0] x);
      @(negedge sys_clk);
      go <= 1'h1;
      leaf <= l;
      idx <= x;
      @(negedge sys_clk);
      go <= 1'h0;
   endtask
   task automatic query(input logic [31:0] l, input logic [31:0] x);
      issue(l, x);
      for (int n = 0; n < 20; n++) begin
         @(negedge sys_clk);
         if (ans === 1'h1) return;
      end
      miscompares++;
      stop_test;
   endtask
   // ==========================================================
   // Stimulus
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      miscompares++;
      stop_test;
   end
   initial begin
      reset_n = 1'h0;
      go = 1'h0;
      misc_wr = 1'h0;
      misc_wdata = 32'h0;
      leaf = 32'h0;
      idx = 32'h0;
      repeat (6) @(negedge sys_clk);
      chk(ready, 1'h0);
      chk(misc_q, 32'h0);
      reset_n <= 1'h1;
      for (int i = 0; i < 11; i++) begin
         misc_write({9'h0, rows[i].hide, 22'h0});
         query(rows[i].leaf, rows[i].idx);
         chk(w0, rows[i].w0);
         chk(w1, rows[i].w1);
         chk(w2, rows[i].w2);
         chk(w3, 32'h0);
         chk(size, rows[i].size);
         chk({hid, unh, nomore}, rows[i].fl);
      end
      misc_write(32'hFFFF_FFFF);
      chk(misc_q, 32'hFFFF_FFFF);
      // Reset lands while a query sits in lookup
      issue(32'h4, 32'h0);
      @(negedge sys_clk);
      reset_n <= 1'h0;
      repeat (3) @(negedge sys_clk);
      chk({ans, w0, misc_q}, 66'h0);
      reset_n <= 1'h1;
      query(32'h4, 32'h1);
      chk(w0, 32'h4122);
      stop_test;
   end
endmodule // cache_parameter_query_bench
